// ### core/scr_config_regs.sv
// Configuration registers 2, 3 and 4 of a serially programmed synthesizer.
// Assumes a host on the three-wire serial pins and a 20 MHz core clock.
//
// How it works
// RULE_01 - Bit 13 enables double buffering.
// RULE_02 - Pump current code, applied on commit.
// RULE_03 - Bit 8 picks fractional or integer lock.
// RULE_04 - Bit 7 picks 10 or 6 ns window.
// RULE_05 - Bit 6 sets detector polarity.
// RULE_06 - Bit 5 set means shutdown.
// RULE_07 - Bit 4 three-states the pump.
// RULE_08 - Bit 3 holds both counters reset.
// RULE_09 - Select 011 loads register 3, resets 0B.
// RULE_10 - Manual band applies only with auto off.
// RULE_11 - Bit 25 clear runs auto band selection.
// RULE_12 - Bit 24 enables drift retuning.
// RULE_13 - Host writes reserved bits as zero.
// RULE_14 - Divider mode: off, fast, phase, reserved.
// RULE_15 - Twelve-bit divider value, zero unused.
// RULE_16 - Select 100 loads register 4, resets.
// RULE_17 - Host keeps lock kind matching mode.
// RULE_18 - Select 010 loads register 2, resets.
// RULE_19 - Buffered fields commit on register 0.
// RULE_20 - Word is select bits plus data.
`timescale 1ns/10ps
`default_nettype none
module scr_config_regs (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        ser_clk,
  input  wire logic        ser_data,
  input  wire logic        ser_load,
  output logic             buffer_commit_enable,
  output logic [3:0]       pump_current_code,
  output logic [12:0]      pump_current_ua,
  output logic             lock_detect_kind,
  output logic             lock_window_select,
  output logic [3:0]       lock_window_ns,
  output logic             detector_polarity,
  output logic             power_down_bit,
  output logic             pump_tristate,
  output logic             counter_reset,
  output logic [5:0]       oscillator_band_select,
  output logic             band_manual_active,
  output logic             auto_band_selector_run,
  output logic             auto_retune_enable,
  output var scr_pkg::scr_cdm_t clock_divider_mode,
  output logic             fast_lock_enable,
  output logic             phase_mode_enable,
  output logic [11:0]      clock_divider_value,
  output logic             divider_tick,
  output logic             reserved_write_seen,
  output logic             commit_pulse,
  output logic [31:0]      output_and_band_config
);
  scr_word_if wif ();

  scr_serial_rx u_rx (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .ser_clk  (ser_clk),
    .ser_data (ser_data),
    .ser_load (ser_load),
    .word_out (wif)
  );

  // Pump current grows in equal steps from one step at code zero.
  function automatic logic [12:0] pump_ua(input logic [3:0] code);
    logic [12:0] steps;
    steps = 13'(code) + 13'h0001;
    return 13'(steps * 13'(scr_pkg::CP_STEP_UA));
  endfunction

  logic        wr0;
  logic        wr2;
  logic        wr3;
  logic        wr4;
  logic [31:0] w;
  assign w   = wif.word;
  // RULE_18 select decode
  assign wr0 = wif.valid && (w[2:0] == scr_pkg::ADDR_R0);
  assign wr2 = wif.valid && (w[2:0] == scr_pkg::ADDR_R2);
  assign wr3 = wif.valid && (w[2:0] == scr_pkg::ADDR_R3);
  assign wr4 = wif.valid && (w[2:0] == scr_pkg::ADDR_R4);

  logic [31:0] loop_and_power_control_q;
  logic [31:0] band_and_clock_divider_q;
  logic [31:0] output_and_band_config_q;
  logic [31:0] reg4_shadow_q;
  logic [3:0]  cp_active_q;
  logic [12:0] cp_ua_q;
  logic [3:0]  win_ns_q;
  logic [5:0]  band_q;
  logic        band_manual_q;
  logic        auto_run_q;
  logic        retune_q;
  logic        rsv_seen_q;
  logic        commit_q;
  logic [11:0] div_cnt_q;
  logic        tick_q;
  logic        div_run;
  logic        db_on;
  logic        fast_q;
  logic        phase_q;

  assign db_on = loop_and_power_control_q[scr_pkg::DB_BIT];

  // RULE_18 register 2 load
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      loop_and_power_control_q <= scr_pkg::R2_RESET;
    end else if (wr2) begin
      loop_and_power_control_q <= w;
    end
  end

  // RULE_19 commit on register 0
  // The written pump code waits here until the next register 0 word.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cp_active_q <= scr_pkg::R2_RESET[scr_pkg::CP_LSB +: scr_pkg::CP_W];
      commit_q    <= 1'b0;
    end else begin
      commit_q <= wr0;
      if (wr0) begin
        cp_active_q <=
          loop_and_power_control_q[scr_pkg::CP_LSB +: scr_pkg::CP_W];
      end
    end
  end

  // RULE_02 current decode
  // RULE_04 window decode
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cp_ua_q  <= pump_ua(4'h0);
      win_ns_q <= scr_pkg::LOCK_WIN_WIDE_NS;
    end else begin
      cp_ua_q  <= pump_ua(cp_active_q);
      win_ns_q <= loop_and_power_control_q[scr_pkg::LDP_BIT] ?
                  scr_pkg::LOCK_WIN_NARROW_NS : scr_pkg::LOCK_WIN_WIDE_NS;
    end
  end

  // RULE_09 register 3 load
  // RULE_13 reserved bits dropped
  // Reserved bits are kept at zero so a careless host cannot reach them.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      band_and_clock_divider_q <= scr_pkg::R3_RESET;
      rsv_seen_q               <= 1'b0;
    end else if (wr3) begin
      band_and_clock_divider_q <= w & ~scr_pkg::R3_RSV_MASK;
      rsv_seen_q               <= |(w & scr_pkg::R3_RSV_MASK);
    end
  end

  // RULE_10 manual band gating
  // RULE_11 auto band run
  // RULE_12 drift retune
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      band_q        <= scr_pkg::R3_RESET[scr_pkg::BAND_LSB +: scr_pkg::BAND_W];
      band_manual_q <= scr_pkg::R3_RESET[scr_pkg::VAS_OFF_BIT];
      auto_run_q    <= !scr_pkg::R3_RESET[scr_pkg::VAS_OFF_BIT];
      retune_q      <= scr_pkg::R3_RESET[scr_pkg::RETUNE_BIT];
    end else begin
      band_manual_q <= band_and_clock_divider_q[scr_pkg::VAS_OFF_BIT];
      auto_run_q    <= !band_and_clock_divider_q[scr_pkg::VAS_OFF_BIT];
      retune_q      <= band_and_clock_divider_q[scr_pkg::RETUNE_BIT];
      if (band_and_clock_divider_q[scr_pkg::VAS_OFF_BIT]) begin
        band_q <= band_and_clock_divider_q[scr_pkg::BAND_LSB +:
                                           scr_pkg::BAND_W];
      end
    end
  end

  // RULE_16 register 4 load
  // RULE_01 buffered divider field
  // With buffering on, only the output divider field waits for commit.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      output_and_band_config_q <= scr_pkg::R4_RESET;
      reg4_shadow_q            <= scr_pkg::R4_RESET;
    end else if (wr4) begin
      reg4_shadow_q <= w;
      if (db_on) begin
        output_and_band_config_q <= {w[31:23],
          output_and_band_config_q[scr_pkg::DIVA_LSB +: scr_pkg::DIVA_W],
          w[19:0]};
      end else begin
        output_and_band_config_q <= w;
      end
    end else if (wr0 && db_on) begin
      output_and_band_config_q[scr_pkg::DIVA_LSB +: scr_pkg::DIVA_W] <=
        reg4_shadow_q[scr_pkg::DIVA_LSB +: scr_pkg::DIVA_W];
    end
  end

  // RULE_14 mode decode
  // RULE_15 divide by value
  // The divider stops while counters are held, in shutdown or on code zero.
  assign div_run = (clock_divider_mode == scr_pkg::SCR_CDM_FAST ||
                    clock_divider_mode == scr_pkg::SCR_CDM_PHASE) &&
                   (clock_divider_value != 12'h000) &&
                   !counter_reset && !power_down_bit;

  always_ff @(posedge core_clk) begin
    if (sys_rst || !div_run) begin
      div_cnt_q <= 12'h000;
      tick_q    <= 1'b0;
    end else if (div_cnt_q >= clock_divider_value - 12'h001) begin
      div_cnt_q <= 12'h000;
      tick_q    <= 1'b1;
    end else begin
      div_cnt_q <= div_cnt_q + 12'h001;
      tick_q    <= 1'b0;
    end
  end

  // RULE_14 mode flags
  // Registered so the mode flags leave the block straight from flops.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fast_q  <= 1'b0;
      phase_q <= 1'b0;
    end else begin
      fast_q  <= clock_divider_mode == scr_pkg::SCR_CDM_FAST;
      phase_q <= clock_divider_mode == scr_pkg::SCR_CDM_PHASE;
    end
  end

  // RULE_01 commit enable
  // RULE_03 lock kind
  // RULE_05 polarity
  // RULE_06 shutdown
  // RULE_07 pump three-state
  // RULE_08 counter reset
  assign buffer_commit_enable = db_on;
  assign pump_current_code    = cp_active_q;
  assign pump_current_ua      = cp_ua_q;
  assign lock_detect_kind     = loop_and_power_control_q[scr_pkg::LDF_BIT];
  assign lock_window_select   = loop_and_power_control_q[scr_pkg::LDP_BIT];
  assign lock_window_ns       = win_ns_q;
  assign detector_polarity    = loop_and_power_control_q[scr_pkg::PDP_BIT];
  assign power_down_bit       = loop_and_power_control_q[scr_pkg::POWER_DOWN_BIT_BIT];
  assign pump_tristate        = loop_and_power_control_q[scr_pkg::TRI_BIT];
  assign counter_reset        = loop_and_power_control_q[scr_pkg::RST_BIT];
  assign oscillator_band_select = band_q;
  assign band_manual_active   = band_manual_q;
  assign auto_band_selector_run = auto_run_q;
  assign auto_retune_enable   = retune_q;
  assign clock_divider_mode   = scr_pkg::scr_cdm_t'(
    band_and_clock_divider_q[scr_pkg::CDM_LSB +: scr_pkg::CDM_W]);
  assign fast_lock_enable     = fast_q;
  assign phase_mode_enable    = phase_q;
  assign clock_divider_value  =
    band_and_clock_divider_q[scr_pkg::CDIV_LSB +: scr_pkg::CDIV_W];
  assign divider_tick         = tick_q;
  assign reserved_write_seen  = rsv_seen_q;
  assign commit_pulse         = commit_q;
  assign output_and_band_config = output_and_band_config_q;

  db_hold_a: assert property ( // RULE_01
    @(posedge core_clk) disable iff (sys_rst)
    wr4 && db_on |=> output_and_band_config_q[22:20] ==
                     $past(output_and_band_config_q[22:20]))
    else $error("buffered divider field changed before commit");

  pump_wait_a: assert property ( // RULE_02
    @(posedge core_clk) disable iff (sys_rst)
    wr2 |=> $stable(pump_current_code))
    else $error("pump code changed without a commit");

  pump_ua_a: assert property ( // RULE_02
    @(posedge core_clk) disable iff (sys_rst)
    wr0 |-> ##2 pump_current_ua ==
      13'((13'($past(loop_and_power_control_q[12:9], 2)) + 13'h1) * 13'd320))
    else $error("pump current does not follow committed code");

  commit_copy_a: assert property ( // RULE_19
    @(posedge core_clk) disable iff (sys_rst)
    wr0 |=> commit_pulse && pump_current_code ==
            $past(loop_and_power_control_q[12:9]))
    else $error("commit did not copy the buffered pump code");

  ctrl_bits_a: assert property ( // RULE_06
    @(posedge core_clk) disable iff (sys_rst)
    wr2 |=> {lock_detect_kind, lock_window_select, detector_polarity,
             power_down_bit, pump_tristate, counter_reset} == $past(w[8:3]))
    else $error("control bits do not match the written word");

  win_ns_a: assert property ( // RULE_04
    @(posedge core_clk) disable iff (sys_rst)
    wr2 |-> ##2 lock_window_ns == ($past(w[7], 2) ? 4'h6 : 4'hA))
    else $error("lock window width wrong");

  reset_vals_a: assert property ( // RULE_09
    @(posedge core_clk)
    sys_rst |=> band_and_clock_divider_q == 32'h0000000B &&
      loop_and_power_control_q == 32'h00004042 &&
      output_and_band_config == 32'h6180B23C)
    else $error("register value after reset wrong");

  band_gate_a: assert property ( // RULE_10
    @(posedge core_clk) disable iff (sys_rst)
    !band_manual_active && !$past(band_manual_active) |->
      $stable(oscillator_band_select))
    else $error("manual band applied while auto selection runs");

  auto_run_a: assert property ( // RULE_11
    @(posedge core_clk) disable iff (sys_rst)
    wr3 |-> ##2 auto_band_selector_run == !$past(w[25], 2))
    else $error("auto band run does not follow disable bit");

  rsv_zero_a: assert property ( // RULE_13
    @(posedge core_clk) disable iff (sys_rst)
    wr3 |=> band_and_clock_divider_q[23:17] == 7'h00 &&
            reserved_write_seen == |$past(w[23:17]))
    else $error("reserved bits stored or not flagged");

  tick_gap_a: assert property ( // RULE_15
    @(posedge core_clk) disable iff (sys_rst)
    divider_tick && div_run && clock_divider_value == 12'h005
      ##1 (div_run && clock_divider_value == 12'h005) [*5] |-> divider_tick)
    else $error("divider period wrong");

  r4_direct_a: assert property ( // RULE_16
    @(posedge core_clk) disable iff (sys_rst)
    wr4 && !db_on |=> output_and_band_config == $past(w))
    else $error("register 4 not loaded");
endmodule
`default_nettype wire

// ### core/scr_pkg.sv
// Constants shared by the synthesizer configuration register block.
// Assumes a single 20 MHz core clock and 32-bit serial register words.
package scr_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int          WORD_W = 32;
  localparam int          ADDR_W = 3;

  // Register select codes in the low three bits of a word.
  localparam logic [2:0] ADDR_R0 = 3'h0;
  localparam logic [2:0] ADDR_R2 = 3'h2;
  localparam logic [2:0] ADDR_R3 = 3'h3;
  localparam logic [2:0] ADDR_R4 = 3'h4;

  // Values after reset.
  localparam logic [31:0] R2_RESET = 32'h00004042;
  localparam logic [31:0] R3_RESET = 32'h0000000B;
  localparam logic [31:0] R4_RESET = 32'h6180B23C;

  // Loop and power control word fields.
  localparam int DB_BIT   = 13;
  localparam int CP_LSB   = 9;
  localparam int CP_W     = 4;
  localparam int LDF_BIT  = 8;
  localparam int LDP_BIT  = 7;
  localparam int PDP_BIT  = 6;
  localparam int POWER_DOWN_BIT_BIT = 5;
  localparam int TRI_BIT  = 4;
  localparam int RST_BIT  = 3;

  // Band and clock divider word fields.
  localparam int          BAND_LSB    = 26;
  localparam int          BAND_W      = 6;
  localparam int          VAS_OFF_BIT = 25;
  localparam int          RETUNE_BIT  = 24;
  localparam logic [31:0] R3_RSV_MASK = 32'h00FE0000;
  localparam int          CDM_LSB     = 15;
  localparam int          CDM_W       = 2;
  localparam int          CDIV_LSB    = 3;
  localparam int          CDIV_W      = 12;

  // Output divider field of the output configuration word.
  localparam int DIVA_LSB = 20;
  localparam int DIVA_W   = 3;

  // Pump current step in microamps and lock windows in nanoseconds.
  localparam int         CP_STEP_UA         = 320;
  localparam int         UA_W               = 13;
  localparam logic [3:0] LOCK_WIN_WIDE_NS   = 4'hA;
  localparam logic [3:0] LOCK_WIN_NARROW_NS = 4'h6;

  typedef enum logic [1:0] {
    SCR_CDM_OFF,
    SCR_CDM_FAST,
    SCR_CDM_PHASE,
    SCR_CDM_RSV
  } scr_cdm_t;
endpackage

// ### core/scr_word_if.sv
// Carries one received 32-bit register word from the serial receiver.
// Assumes source and sink share core_clk; valid is a one-cycle pulse.
`timescale 1ns/10ps
`default_nettype none
interface scr_word_if;
  logic [31:0] word;
  logic        valid;
  modport src (output word, output valid);
  modport snk (input word, input valid);
endinterface
`default_nettype wire

// ### core/scr_serial_rx.sv
// Three-wire serial word receiver for the configuration registers.
// Assumes the serial pins change slowly against core_clk (clock high and
// low each last at least three core cycles).
`timescale 1ns/10ps
`default_nettype none
module scr_serial_rx (
  input  wire logic   core_clk,
  input  wire logic   sys_rst,
  input  wire logic   ser_clk,
  input  wire logic   ser_data,
  input  wire logic   ser_load,
  scr_word_if.src     word_out
);
  logic [2:0]  meta_q;
  logic [2:0]  sync_q;
  logic        clk_prev_q;
  logic        load_prev_q;
  logic [31:0] shift_q;
  logic [31:0] word_q;
  logic        valid_q;

  // Pins are asynchronous, so each passes two flops before use.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
    end else begin
      meta_q <= {ser_load, ser_data, ser_clk};
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      clk_prev_q  <= 1'b0;
      load_prev_q <= 1'b0;
    end else begin
      clk_prev_q  <= sync_q[0];
      load_prev_q <= sync_q[2];
    end
  end

  // RULE_20 whole word shift
  // Data enter MSB first, so the select bits arrive last.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      shift_q <= 32'h00000000;
    end else if (sync_q[0] && !clk_prev_q) begin
      shift_q <= {shift_q[30:0], sync_q[1]};
    end
  end

  // RULE_20 word on load
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      word_q  <= 32'h00000000;
      valid_q <= 1'b0;
    end else begin
      valid_q <= sync_q[2] && !load_prev_q;
      if (sync_q[2] && !load_prev_q) begin
        word_q <= shift_q;
      end
    end
  end

  assign word_out.word  = word_q;
  assign word_out.valid = valid_q;
endmodule
`default_nettype wire

// ### testbench/scr_host_model.sv
// Host model that writes 32-bit words on the three-wire serial pins.
// Assumes core_clk is the bench clock; clock and data phases last 4 cycles, the load pulse 8.
`timescale 1ns/10ps
`default_nettype none
module scr_host_model (
  input  wire logic core_clk,
  output var logic  ser_clk,
  output var logic  ser_data,
  output var logic  ser_load
);
  initial begin
    ser_clk  = 1'b0;
    ser_data = 1'b0;
    ser_load = 1'b0;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic send(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      ser_data = w[i];
      wait_cyc(4);
      ser_clk = 1'b1;
      wait_cyc(4);
      ser_clk = 1'b0;
    end
    // A released data pin shows the inverse so a stale bit never passes.
    ser_data = ~w[0];
    wait_cyc(4);
    ser_load = 1'b1;
    wait_cyc(8);
    ser_load = 1'b0;
    wait_cyc(4);
  endtask
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the configuration register block.
// Assumes the host model drives the serial pins from one 20 MHz clock.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [31:0] word;
    logic [12:0] ua;
    logic [3:0]  ns;
    logic [5:0]  band;
    logic [1:0]  fp;
  } scr_row_t;

  logic              core_clk = 1'b0;
  logic              sys_rst;
  logic              ser_clk;
  logic              ser_data;
  logic              ser_load;
  logic              bce;
  logic              kind;
  logic              win_sel;
  logic              pol;
  logic              pd;
  logic              tri_st;
  logic              cnt_rst;
  logic              manual;
  logic              auto_run;
  logic              retune;
  logic              fast;
  logic              phase;
  logic              tick;
  logic              rsv;
  logic              commit;
  logic [3:0]        code;
  logic [3:0]        win_ns;
  logic [3:0]        prev_code;
  logic [12:0]       ua;
  logic [5:0]        band;
  logic [11:0]       div_val;
  logic [31:0]       reg4;
  scr_pkg::scr_cdm_t mode;
  int                errors = 0;
  int                compares = 0;
  int                cycles = 0;
  int                commits = 0;
  int                ticks = 0;
  logic [2:0]        bad [4] = '{3'h1, 3'h5, 3'h6, 3'h7};
  // Reserved bits stay zero in every row.
  scr_row_t          rows [8] = '{
    '{32'h00003FFA, 13'd5120, 4'd6, 6'd0, 2'b00},
    '{32'h00000002, 13'd320, 4'd10, 6'd0, 2'b00},
    '{32'h00000A92, 13'd1920, 4'd6, 6'd0, 2'b00},
    '{32'hFFFFC142, 13'd320, 4'd10, 6'd0, 2'b00},
    '{32'hFF01FFFB, 13'd0, 4'd0, 6'd63, 2'b00},
    '{32'h0800800B, 13'd0, 4'd0, 6'd63, 2'b10},
    '{32'h0601000B, 13'd0, 4'd0, 6'd1, 2'b01},
    '{32'h0000000B, 13'd0, 4'd0, 6'd1, 2'b00}};

  scr_host_model host (
    .core_clk (core_clk),
    .ser_clk  (ser_clk),
    .ser_data (ser_data),
    .ser_load (ser_load)
  );

  scr_config_regs dut (
    .core_clk               (core_clk),
    .sys_rst                (sys_rst),
    .ser_clk                (ser_clk),
    .ser_data               (ser_data),
    .ser_load               (ser_load),
    .buffer_commit_enable   (bce),
    .pump_current_code      (code),
    .pump_current_ua        (ua),
    .lock_detect_kind       (kind),
    .lock_window_select     (win_sel),
    .lock_window_ns         (win_ns),
    .detector_polarity      (pol),
    .power_down_bit         (pd),
    .pump_tristate          (tri_st),
    .counter_reset          (cnt_rst),
    .oscillator_band_select (band),
    .band_manual_active     (manual),
    .auto_band_selector_run (auto_run),
    .auto_retune_enable     (retune),
    .clock_divider_mode     (mode),
    .fast_lock_enable       (fast),
    .phase_mode_enable      (phase),
    .clock_divider_value    (div_val),
    .divider_tick           (tick),
    .reserved_write_seen    (rsv),
    .commit_pulse           (commit),
    .output_and_band_config (reg4)
  );

  always #25 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles++;
    if (commit) commits++;
    if (tick) ticks++;
    // The run should need about 8200 cycles.
    if (cycles == 15000) begin
      errors++;
      summarize();
    end
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic chk_cnt(input string n, input int e, input int g);
    compares++;
    if (g != e) begin
      errors++;
      $display("CHECK FAILED %s expected %0d seen %0d", n, e, g);
    end
  endtask

  task automatic summarize();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic do_reset();
    sys_rst = 1'b1;
    repeat (4) @(posedge core_clk);
    #1 sys_rst = 1'b0;
  endtask

  task automatic check_reset();
    chk("reg4", scr_pkg::R4_RESET, reg4);
    chk("ctl", 32'h8, 32'({bce, kind, win_sel, pol, pd, tri_st, cnt_rst}));
    chk("ua", 32'd320, 32'(ua));
    chk("ns", 32'd10, 32'(win_ns));
    chk("auto", 32'h4, 32'({auto_run, manual, retune}));
    chk("div", 32'h1, 32'({mode, div_val}));
    chk("band", 32'h0, 32'({rsv, band}));
  endtask

  // The reg0 word carries the integer flag matching the lock kind.
  // mode matches kind
  task automatic commit_w(input int n);
    host.send({kind, 31'h0});
    chk_cnt("commit", n + 1, commits);
  endtask

  // Only the clock process writes the tick count; this task takes a delta.
  task automatic count_ticks(input int e);
    int start;
    start = ticks;
    repeat (50) @(posedge core_clk);
    #1;
    chk_cnt("ticks", e, ticks - start);
  endtask

  initial begin
    logic [31:0] w;
    sys_rst = 1'b1;
    do_reset();
    check_reset();
    $display("test reset done");
    prev_code = 4'h0;
    foreach (rows[i]) begin
      w = rows[i].word;
      host.send(w);
      if (w[2:0] == scr_pkg::ADDR_R2) begin
        chk("ctl", 32'({w[13], w[8:3]}), 32'({bce, kind, win_sel, pol, pd, tri_st, cnt_rst}));
        chk("ns", 32'(rows[i].ns), 32'(win_ns));
        chk("held", 32'(prev_code), 32'(code));
        commit_w(commits);
        chk("code", 32'(w[12:9]), 32'(code));
        chk("ua", 32'(rows[i].ua), 32'(ua));
        prev_code = w[12:9];
      end else begin
        chk("auto", 32'({~w[25], w[25], w[24]}), 32'({auto_run, manual, retune}));
        chk("band", 32'(rows[i].band), 32'(band));
        chk("mode", 32'(w[16:15]), 32'(mode));
        chk("fp", 32'(rows[i].fp), 32'({fast, phase}));
        chk("div", 32'(w[14:3]), 32'(div_val));
      end
      $display("test row %0d done", i);
    end
    host.send(32'h0000802B);
    count_ticks(10);
    host.send(32'h0000000A);
    count_ticks(0);
    host.send(32'h00000022);
    count_ticks(0);
    host.send(32'h00000002);
    count_ticks(10);
    host.send(32'h0001002B);
    count_ticks(10);
    host.send(32'h0001802B);
    count_ticks(0);
    $display("test divider done");
    host.send(32'h0010000B);
    chk("rsv", 32'h1, 32'(rsv));
    host.send(32'h0000000B);
    chk("rsv", 32'h0, 32'(rsv));
    $display("test reserved done");
    foreach (bad[i]) begin
      host.send({29'h1FFFFFFF, bad[i]});
      chk("reg4", scr_pkg::R4_RESET, reg4);
      chk("ctl", 32'h0, 32'({bce, kind, pd, tri_st, cnt_rst, code}));
      chk("div", 32'h1, 32'(div_val));
    end
    $display("test refused done");
    host.send(32'h00002002);
    chk("bce", 32'h1, 32'(bce));
    host.send(32'h12345674);
    chk("reg4", 32'h12045674, reg4);
    commit_w(commits);
    chk("reg4", 32'h12345674, reg4);
    host.send(32'h00000002);
    host.send(32'h6180B23C);
    chk("reg4", 32'h6180B23C, reg4);
    $display("test buffer done");
    do_reset();
    check_reset();
    $display("test second reset done");
    summarize();
  end
endmodule
`default_nettype wire
